// file: core/hfp_mem.sv
// Small dual-port word memory with registered, write-first read data.
`timescale 1ns/1ps
module hfp_mem #(
  parameter int W = 32,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Bypass so a word pushed into an empty queue is the head on the next cycle.
  always_ff @(posedge clk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// file: core/hfp_queue.sv
// One first-in first-out queue with a run-time size limit and a flush.
`timescale 1ns/1ps
module hfp_queue #(
  parameter int W = 32,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [AW:0] limit,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic [AW:0] level,
  output logic drop,
  output logic underrun
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] level_q;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] raddr;

  assign do_push = push && (level_q < limit) && (level_q < DEPTH);
  assign do_pop = pop && (level_q != '0);
  assign drop = push && !do_push;
  assign underrun = pop && !do_pop;
  assign level = level_q;
  assign raddr = flush ? '0 : (do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q);

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      level_q <= level_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  hfp_mem #(.W(W), .AW(AW)) u_mem (
    .clk(clk),
    .we(do_push && !flush),
    .waddr(wr_ptr_q),
    .wdata(push_data),
    .raddr(raddr),
    .rdata(head)
  );
endmodule

// file: core/hfp_top.sv
// Host access to the four data-path queues and their control and status words.
`timescale 1ns/1ps
module hfp_top
  import hfp_pkg::*;
#(
  parameter int AW = 6
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] HOST_ADDR,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic [DATA_W-1:0] HOST_WDATA,
  output logic [DATA_W-1:0] HOST_RDATA,
  output logic HOST_RVALID,
  input wire logic RXS_PUSH,
  input wire logic [DATA_W-1:0] RXS_DATA,
  output logic RXS_FULL,
  input wire logic RXD_PUSH,
  input wire logic [DATA_W-1:0] RXD_DATA,
  output logic RXD_FULL,
  input wire logic TXS_PUSH,
  input wire logic [DATA_W-1:0] TXS_DATA,
  output logic TXS_FULL,
  input wire logic TXD_POP,
  output logic [DATA_W-1:0] TXD_DATA,
  output logic TXD_VALID,
  input wire logic EVT_HIGH_IN,
  input wire logic EVT_LOW_IN,
  output logic SOFT_RESET_ACTIVE
);

  localparam int LW = AW + 1;

  // Decoded host accesses.
  logic rd_rxd;
  logic wr_txd;
  logic rd_rxs_pop;
  logic rd_txs_pop;
  logic wr_cfg;
  logic wr_evt;
  logic rd_evt;
  logic rd_latch;
  logic rd_drop;
  logic host_wr_ok;

  // Control and status state.
  logic soft_rst_q;
  logic keep_q;
  logic [LW-1:0] lim_rxd_q;
  logic [LW-1:0] lim_rxs_q;
  logic [LW-1:0] lim_txd_q;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] evt_set;
  logic latch_hi_q;
  logic latch_lo_q;
  logic [DROP_W-1:0] drop_q;
  logic drop_any;

  // Queue ports.
  logic [DATA_W-1:0] rxs_head;
  logic [DATA_W-1:0] rxd_head;
  logic [DATA_W-1:0] txs_head;
  logic [DATA_W-1:0] txd_head;
  logic [LW-1:0] rxs_level;
  logic [LW-1:0] rxd_level;
  logic [LW-1:0] txs_level;
  logic [LW-1:0] txd_level;
  logic rxs_drop;
  logic rxd_drop;
  logic txs_drop;
  logic txd_drop;
  logic rxs_under;
  logic rxd_under;
  logic txs_under;
  logic txd_pop_ok;
  logic [LW-1:0] txs_limit;

  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic rxs_full_q;
  logic rxd_full_q;
  logic txs_full_q;

  // A read and a write in the same cycle is taken as a read only.
  assign host_wr_ok = HOST_WR && !HOST_RD;
  assign rd_rxd = HOST_RD && in_window(HOST_ADDR, RXD_BASE);
  assign wr_txd = host_wr_ok && in_window(HOST_ADDR, TXD_BASE);
  assign rd_rxs_pop = HOST_RD && (HOST_ADDR == RXS_POP_ADDR);
  assign rd_txs_pop = HOST_RD && (HOST_ADDR == TXS_POP_ADDR);
  assign wr_cfg = host_wr_ok && (HOST_ADDR == CFG_ADDR);
  assign wr_evt = host_wr_ok && (HOST_ADDR == EVENT_ADDR);
  assign rd_evt = HOST_RD && (HOST_ADDR == EVENT_ADDR);
  assign rd_latch = HOST_RD && (HOST_ADDR == LATCH_ADDR);
  assign rd_drop = HOST_RD && (HOST_ADDR == DROP_ADDR);
  assign txd_pop_ok = TXD_POP && (txd_level != '0);
  // The transmit status queue has no size field of its own.
  assign txs_limit = LW'(1 << AW);

  // Receive status: pop port removes, peek port only reads.
  hfp_queue #(.W(DATA_W), .AW(AW)) u_rxs (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_rst_q),
    .limit(lim_rxs_q),
    .push(RXS_PUSH),
    .push_data(RXS_DATA),
    .pop(rd_rxs_pop),
    .head(rxs_head),
    .level(rxs_level),
    .drop(rxs_drop),
    .underrun(rxs_under)
  );

  // Receive data: every read at any alias pops; no host path writes it.
  hfp_queue #(.W(DATA_W), .AW(AW)) u_rxd (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_rst_q),
    .limit(lim_rxd_q),
    .push(RXD_PUSH),
    .push_data(RXD_DATA),
    .pop(rd_rxd),
    .head(rxd_head),
    .level(rxd_level),
    .drop(rxd_drop),
    .underrun(rxd_under)
  );

  // Transmit status: filled by the transmitter, read by the host.
  hfp_queue #(.W(DATA_W), .AW(AW)) u_txs (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_rst_q),
    .limit(txs_limit),
    .push(TXS_PUSH),
    .push_data(TXS_DATA),
    .pop(rd_txs_pop),
    .head(txs_head),
    .level(txs_level),
    .drop(txs_drop),
    .underrun(txs_under)
  );

  // Transmit data: each host write at any alias appends one word.
  hfp_queue #(.W(DATA_W), .AW(AW)) u_txd (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_rst_q),
    .limit(lim_txd_q),
    .push(wr_txd),
    .push_data(HOST_WDATA),
    .pop(TXD_POP),
    .head(txd_head),
    .level(txd_level),
    .drop(txd_drop),
    .underrun()
  );

  // Soft reset is self-clearing: one cycle wide, then the bit reads zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_cfg && HOST_WDATA[SOFT_RST_BIT];
    end
  end

  // The keep bit is the one control bit that soft reset leaves alone.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      keep_q <= 1'b0;
    end else if (wr_cfg) begin
      keep_q <= HOST_WDATA[KEEP_BIT];
    end
  end

  // Size limits take effect for later pushes; entries above a lowered limit stay.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      lim_rxd_q <= LIMIT_RESET[LW-1:0];
      lim_rxs_q <= LIMIT_RESET[LW-1:0];
      lim_txd_q <= LIMIT_RESET[LW-1:0];
    end else if (wr_cfg) begin
      lim_rxd_q <= HOST_WDATA[RXD_FIELD +: LW];
      lim_rxs_q <= HOST_WDATA[RXS_FIELD +: LW];
      lim_txd_q <= HOST_WDATA[TXD_FIELD +: LW];
    end
  end

  // Sticky event flags; a new event in the clearing cycle is kept.
  always_comb begin
    evt_set = '0;
    evt_set[EVT_RXD_OVF] = rxd_drop;
    evt_set[EVT_RXS_OVF] = rxs_drop;
    evt_set[EVT_TXS_OVF] = txs_drop;
    evt_set[EVT_TXD_OVF] = txd_drop;
    evt_set[EVT_UNDERRUN] = rxs_under || rxd_under || txs_under;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      evt_q <= EVENT_RESET;
    end else if (wr_evt) begin
      evt_q <= (evt_q & ~HOST_WDATA[EVT_W-1:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  // High latch catches any high level, so a short pulse is not missed between reads.
  // Reading the register releases it to the present input level.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      latch_hi_q <= 1'b0;
    end else if (rd_latch) begin
      latch_hi_q <= EVT_HIGH_IN;
    end else begin
      latch_hi_q <= latch_hi_q | EVT_HIGH_IN;
    end
  end

  // Low latch catches any low level and is released in the same way.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      latch_lo_q <= 1'b1;
    end else if (rd_latch) begin
      latch_lo_q <= EVT_LOW_IN;
    end else begin
      latch_lo_q <= latch_lo_q & EVT_LOW_IN;
    end
  end

  // Dropped-entry counter, cleared by reading; it saturates rather than wraps.
  assign drop_any = rxd_drop || rxs_drop || txs_drop;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      drop_q <= DROP_RESET;
    end else if (rd_drop) begin
      drop_q <= DROP_W'(drop_any);
    end else if (drop_any && (drop_q != '1)) begin
      drop_q <= drop_q + 1'b1;
    end
  end

  // Read data selection; write-only and reserved locations read as zero.
  always_comb begin
    rd_mux = '0;
    if (in_window(HOST_ADDR, RXD_BASE)) begin
      rd_mux = rxd_head;
    end else if (in_window(HOST_ADDR, TXD_BASE)) begin
      rd_mux = '0;
    end else begin
      unique case (HOST_ADDR)
        RXS_POP_ADDR, RXS_PEEK_ADDR: begin
          rd_mux = rxs_head;
        end
        TXS_POP_ADDR, TXS_PEEK_ADDR: begin
          rd_mux = txs_head;
        end
        CFG_ADDR: begin
          rd_mux[RXD_FIELD +: LW] = lim_rxd_q;
          rd_mux[RXS_FIELD +: LW] = lim_rxs_q;
          rd_mux[TXD_FIELD +: LW] = lim_txd_q;
          rd_mux[KEEP_BIT] = keep_q;
        end
        LEVEL_ADDR: begin
          rd_mux[RXD_FIELD +: LW] = rxd_level;
          rd_mux[RXS_FIELD +: LW] = rxs_level;
          rd_mux[TXD_FIELD +: LW] = txd_level;
          rd_mux[TXS_FIELD +: LW] = txs_level;
        end
        EVENT_ADDR: begin
          rd_mux[EVT_W-1:0] = evt_q;
        end
        LATCH_ADDR: begin
          rd_mux[LATCH_HIGH_BIT] = latch_hi_q;
          rd_mux[LATCH_LOW_BIT] = latch_lo_q;
        end
        DROP_ADDR: begin
          rd_mux[DROP_W-1:0] = drop_q;
        end
        default: begin
          rd_mux = '0;
        end
      endcase
    end
  end

  // Read answer strobe, one cycle after each read.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= HOST_RD;
    end
  end

  // Writes to status, level and receive addresses decode to nothing.
  // The read data hold until the next read, so a slow host may take them late.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else if (HOST_RD) begin
      rdata_q <= rd_mux;
    end
  end

  // Back-pressure flags for the producers, one cycle behind the levels.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      rxs_full_q <= 1'b0;
      rxd_full_q <= 1'b0;
      txs_full_q <= 1'b0;
    end else begin
      rxs_full_q <= rxs_level >= lim_rxs_q;
      rxd_full_q <= rxd_level >= lim_rxd_q;
      txs_full_q <= txs_level >= txs_limit;
    end
  end

  // Transmit data seen by the transmitter; valid tracks the level, head is a flop.
  logic txd_valid_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || soft_rst_q) begin
      txd_valid_q <= 1'b0;
    end else begin
      txd_valid_q <= (txd_level + LW'(wr_txd && !txd_drop) - LW'(txd_pop_ok)) != '0;
    end
  end

  assign HOST_RDATA = rdata_q;
  assign HOST_RVALID = rvalid_q;
  assign RXS_FULL = rxs_full_q;
  assign RXD_FULL = rxd_full_q;
  assign TXS_FULL = txs_full_q;
  assign TXD_DATA = txd_head;
  assign TXD_VALID = txd_valid_q;
  assign SOFT_RESET_ACTIVE = soft_rst_q;

endmodule

// file: include/hfp_pkg.sv
// Constants and address helpers for the host queue port block.
package hfp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ALIAS_WORDS = 16;

  localparam logic [7:0] RXD_BASE = 8'h00;
  localparam logic [7:0] TXD_BASE = 8'h40;
  localparam logic [7:0] RXS_POP_ADDR = 8'h80;
  localparam logic [7:0] RXS_PEEK_ADDR = 8'h84;
  localparam logic [7:0] TXS_POP_ADDR = 8'h88;
  localparam logic [7:0] TXS_PEEK_ADDR = 8'h8c;
  localparam logic [7:0] CFG_ADDR = 8'h90;
  localparam logic [7:0] LEVEL_ADDR = 8'h94;
  localparam logic [7:0] EVENT_ADDR = 8'h98;
  localparam logic [7:0] LATCH_ADDR = 8'h9c;
  localparam logic [7:0] DROP_ADDR = 8'ha0;

  // Byte lanes of the limit and level fields, and single bit positions.
  localparam int RXD_FIELD = 0;
  localparam int RXS_FIELD = 8;
  localparam int TXD_FIELD = 16;
  localparam int TXS_FIELD = 24;
  localparam int SOFT_RST_BIT = 30;
  localparam int KEEP_BIT = 31;
  localparam int EVT_RXD_OVF = 0;
  localparam int EVT_RXS_OVF = 1;
  localparam int EVT_TXS_OVF = 2;
  localparam int EVT_TXD_OVF = 3;
  localparam int EVT_UNDERRUN = 4;
  localparam int EVT_W = 5;
  localparam int LATCH_HIGH_BIT = 0;
  localparam int LATCH_LOW_BIT = 1;
  localparam int DROP_W = 16;

  localparam logic [7:0] LIMIT_RESET = 8'h40;
  localparam logic [EVT_W-1:0] EVENT_RESET = 5'h00;
  localparam logic [DROP_W-1:0] DROP_RESET = 16'h0000;

  function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
    in_window = (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0);
  endfunction

endpackage

// file: tb/hfp_host_model.sv
// Behavioural host processor making single-word register-bus cycles.
`timescale 1ns/1ps
module hfp_host_model
  import hfp_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] addr,
  output logic rd,
  output logic wr,
  output logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
  end
  // Callers pass only mapped addresses with reserved bits zero.
  // Idle lines show the inverse so a stale value is never mistaken for a held one.
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d, output bit late);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    late = (rvalid !== 1'b1);
    d = rdata;
  endtask
endmodule

// file: tb/hfp_top_monitor.sv
// Concurrent checks on the pins of the host queue port block.
`timescale 1ns/1ps
module hfp_top_monitor
  import hfp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] HOST_ADDR,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic [DATA_W-1:0] HOST_WDATA,
  input wire logic [DATA_W-1:0] HOST_RDATA,
  input wire logic HOST_RVALID,
  input wire logic RXS_FULL,
  input wire logic RXD_FULL,
  input wire logic TXD_POP,
  input wire logic [DATA_W-1:0] TXD_DATA,
  input wire logic TXD_VALID,
  input wire logic SOFT_RESET_ACTIVE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_answer;
    HOST_RD |=> HOST_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rvalid_cause;
    HOST_RVALID |-> $past(HOST_RD);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
  property p_txwin_zero;
    HOST_RD && HOST_ADDR[7:6] == 2'h1 |=> HOST_RDATA == 32'h0;
  endproperty
  a_txwin_zero: assert property (p_txwin_zero) else $error("tx window read not zero");
  // An earlier configuration write could flush the queue or zero its limit and lose the word.
  property p_txd_push;
    (HOST_WR && !HOST_RD && HOST_ADDR[7:6] == 2'h1 && HOST_ADDR[1:0] == 2'h0 && !TXD_VALID
      && !$past(HOST_WR)) ##1 !TXD_POP |=> TXD_VALID && TXD_DATA == $past(HOST_WDATA, 2);
  endproperty
  a_txd_push: assert property (p_txd_push) else $error("tx word not queued");
  property p_txd_pop_empty;
    TXD_POP && !TXD_VALID && !HOST_WR && !$past(HOST_WR) |=> !TXD_VALID;
  endproperty
  a_txd_pop_empty: assert property (p_txd_pop_empty) else $error("empty pop moved queue");
  property p_soft_start;
    HOST_WR && !HOST_RD && HOST_ADDR == CFG_ADDR && HOST_WDATA[SOFT_RST_BIT] |=> SOFT_RESET_ACTIVE;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft reset not started");
  property p_soft_pulse;
    SOFT_RESET_ACTIVE |=> !SOFT_RESET_ACTIVE;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
  property p_soft_flush;
    SOFT_RESET_ACTIVE |-> ##2 (!TXD_VALID && !RXS_FULL && !RXD_FULL);
  endproperty
  a_soft_flush: assert property (p_soft_flush) else $error("queues not flushed");
endmodule
bind hfp_top hfp_top_monitor i_hfp_top_monitor (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA),
  .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID), .RXS_FULL(RXS_FULL),
  .RXD_FULL(RXD_FULL), .TXD_POP(TXD_POP), .TXD_DATA(TXD_DATA), .TXD_VALID(TXD_VALID),
  .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE));

// file: tb/hfp_top_tb_top.sv
// Self-checking bench for the host queue port block.
`timescale 1ns/1ps
module hfp_top_tb_top;
  import hfp_pkg::*;
  logic core_clk;
  logic rst_n;
  logic [7:0] host_addr;
  logic host_rd;
  logic host_wr;
  logic [31:0] host_wdata;
  logic [31:0] host_rdata;
  logic host_rvalid;
  logic rxs_push;
  logic [31:0] rxs_data;
  logic rxs_full;
  logic rxd_push;
  logic [31:0] rxd_data;
  logic rxd_full;
  logic txs_push;
  logic [31:0] txs_data;
  logic txs_full;
  logic txd_pop;
  logic [31:0] txd_data;
  logic txd_valid;
  logic evt_high_in;
  logic evt_low_in;
  logic soft_reset_active;
  int mismatches;
  int n_compared;
  hfp_top i_hfp_top (.CORE_CLK(core_clk), .RST_N(rst_n), .HOST_ADDR(host_addr),
    .HOST_RD(host_rd), .HOST_WR(host_wr), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .HOST_RVALID(host_rvalid), .RXS_PUSH(rxs_push), .RXS_DATA(rxs_data), .RXS_FULL(rxs_full),
    .RXD_PUSH(rxd_push), .RXD_DATA(rxd_data), .RXD_FULL(rxd_full), .TXS_PUSH(txs_push),
    .TXS_DATA(txs_data), .TXS_FULL(txs_full), .TXD_POP(txd_pop), .TXD_DATA(txd_data),
    .TXD_VALID(txd_valid), .EVT_HIGH_IN(evt_high_in), .EVT_LOW_IN(evt_low_in),
    .SOFT_RESET_ACTIVE(soft_reset_active));
  hfp_host_model i_hfp_host_model (.clk(core_clk), .addr(host_addr), .rd(host_rd),
    .wr(host_wr), .wdata(host_wdata), .rdata(host_rdata), .rvalid(host_rvalid));
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", w, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_hfp_host_model.wr_word(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] d;
    bit late;
    i_hfp_host_model.rd_word(a, d, late);
    if (late) begin
      $display("wrong value %s answer expected 1 seen 0", w);
      mismatches++;
      wrap_up();
    end else begin
      chk(w, e, d);
    end
  endtask
  task automatic push(input int k, input logic [31:0] d);
    @(negedge core_clk);
    rxs_push = (k == 0);
    rxd_push = (k == 1);
    txs_push = (k == 2);
    rxs_data = d;
    rxd_data = d;
    txs_data = d;
    @(negedge core_clk);
    rxs_push = 1'b0;
    rxd_push = 1'b0;
    txs_push = 1'b0;
  endtask
  task automatic t_rx_status();
    push(0, 32'h1111_0001);
    push(0, 32'h2222_0002);
    wr(RXS_POP_ADDR, 32'h0);
    wr(LEVEL_ADDR, 32'h7f7f_7f7f);
    rd_chk(LEVEL_ADDR, 32'h0000_0200, "levels");
    rd_chk(RXS_PEEK_ADDR, 32'h1111_0001, "rx status peek");
    rd_chk(RXS_PEEK_ADDR, 32'h1111_0001, "rx status peek");
    rd_chk(RXS_POP_ADDR, 32'h1111_0001, "rx status pop");
    rd_chk(RXS_POP_ADDR, 32'h2222_0002, "rx status pop");
  endtask
  task automatic t_rx_data();
    logic [31:0] junk;
    bit late;
    for (int i = 0; i < ALIAS_WORDS; i++) begin
      push(1, 32'h0000_00a0 + 32'(i));
    end
    wr(RXD_BASE, 32'h0);
    for (int i = 0; i < ALIAS_WORDS; i++) begin
      rd_chk(RXD_BASE + 8'(4 * i), 32'h0000_00a0 + 32'(i), "rx data");
    end
    // The value of an empty pop is undefined, so only its side effects are judged.
    i_hfp_host_model.rd_word(RXD_BASE + 8'h3c, junk, late);
    rd_chk(LEVEL_ADDR, 32'h0, "levels after empty pop");
    rd_chk(EVENT_ADDR, 32'h10, "events");
    wr(EVENT_ADDR, 32'h0);
    rd_chk(EVENT_ADDR, 32'h10, "events after zero write");
    wr(EVENT_ADDR, 32'h10);
    rd_chk(EVENT_ADDR, 32'h0, "events after one write");
  endtask
  task automatic t_tx_data();
    for (int i = 0; i < ALIAS_WORDS; i++) begin
      wr(TXD_BASE + 8'(4 * i), 32'h0000_00b0 + 32'(i));
    end
    rd_chk(TXD_BASE + 8'h04, 32'h0, "tx data read");
    for (int i = 0; i < ALIAS_WORDS; i++) begin
      @(negedge core_clk);
      chk("tx data", 32'h0000_00b0 + 32'(i), txd_data);
      txd_pop = 1'b1;
      @(negedge core_clk);
      txd_pop = 1'b0;
    end
    @(negedge core_clk);
    txd_pop = 1'b1;
    @(negedge core_clk);
    txd_pop = 1'b0;
    @(negedge core_clk);
    chk("tx valid", 32'h0, {31'h0, txd_valid});
  endtask
  task automatic t_tx_status();
    push(2, 32'h3333_0003);
    push(2, 32'h4444_0004);
    rd_chk(TXS_PEEK_ADDR, 32'h3333_0003, "tx status peek");
    rd_chk(TXS_POP_ADDR, 32'h3333_0003, "tx status pop");
    rd_chk(TXS_PEEK_ADDR, 32'h4444_0004, "tx status peek");
    rd_chk(TXS_POP_ADDR, 32'h4444_0004, "tx status pop");
    // The transmit status depth is fixed at 64, so the last of these pushes is dropped.
    for (int i = 0; i <= 64; i++) begin
      push(2, 32'(i));
    end
    chk("tx status full", 32'h1, {31'h0, txs_full});
    rd_chk(DROP_ADDR, 32'h1, "drop count tx status");
    rd_chk(EVENT_ADDR, 32'h4, "events after tx status drop");
    wr(EVENT_ADDR, 32'h4);
  endtask
  task automatic t_latch();
    @(negedge core_clk);
    evt_high_in = 1'b1;
    evt_low_in = 1'b0;
    @(negedge core_clk);
    evt_high_in = 1'b0;
    evt_low_in = 1'b1;
    rd_chk(LATCH_ADDR, 32'h1, "latched status");
    rd_chk(LATCH_ADDR, 32'h2, "released status");
  endtask
  task automatic t_drop_reset();
    wr(CFG_ADDR, 32'h8040_0240);
    rd_chk(CFG_ADDR, 32'h8040_0240, "config");
    push(0, 32'h1);
    push(0, 32'h2);
    push(0, 32'h3);
    chk("rx status full", 32'h1, {31'h0, rxs_full});
    rd_chk(LEVEL_ADDR, 32'h4000_0200, "levels");
    rd_chk(DROP_ADDR, 32'h1, "drop count");
    rd_chk(DROP_ADDR, 32'h0, "drop count");
    rd_chk(EVENT_ADDR, 32'h2, "events after rx status drop");
    wr(CFG_ADDR, 32'hc040_0240);
    repeat (2) @(negedge core_clk);
    rd_chk(CFG_ADDR, 32'h8040_4040, "config after soft reset");
    rd_chk(LEVEL_ADDR, 32'h0, "levels after soft reset");
    rd_chk(EVENT_ADDR, 32'h0, "events after soft reset");
    chk("tx status full after soft reset", 32'h0, {31'h0, txs_full});
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    rd_chk(CFG_ADDR, 32'h0040_4040, "config after reset");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    rxs_push = 1'b0;
    rxd_push = 1'b0;
    txs_push = 1'b0;
    rxs_data = 32'h0;
    rxd_data = 32'h0;
    txs_data = 32'h0;
    txd_pop = 1'b0;
    evt_high_in = 1'b0;
    evt_low_in = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_rx_status();
    t_rx_data();
    t_tx_data();
    t_tx_status();
    t_latch();
    t_drop_reset();
    wrap_up();
  end
endmodule
